// ===== inc/inquiry_rom_pkg.sv
// constants, types and reset values for the video mode and frame-rate inquiry words
// assumes a single 100 MHz clock and a host read port inside the camera's 1394 link logic
//
// Behaviour
// [R1] each mode flag is 1 when that format and mode pairing is supported, else 0
// [R2] each rate flag is 1 when that format, mode and rate is supported, else 0
// [R3] format 0 word at 0x180 has bit 1 set in both variants
// [R4] format 0 bit 3 reads 1 only in the colour variant
// [R5] format 0 bits 5 and 6 read 1 in both variants
// [R6] format 0 bits 0, 2 and 4 read 0 in both variants
// [R7] format 0 bit 7 and bits 8 to 31 of every word read 0
// [R8] format 1 word at 0x184 has bits 2, 5, 6, 7 set in both variants
// [R9] format 1 bits 0 and 3 read 1 only in the colour variant
// [R10] format 1 bits 1 and 4 read 0 in both variants
// [R11] format 2 word at 0x188 has bits 2, 5, 6, 7 set in both variants
// [R12] format 2 bits 0 and 3 read 1 only in the colour variant
// [R13] format 2 bits 1 and 4 read 0 in both variants
// [R14] format 7 word at 0x19c: bit 0 set, bit 1 colour only, 2 to 7 clear
// [R15] rate word at 0x204 has bits 0 to 4 set, 5 to 7 clear
// [R16] rate bit n means 1.875 fps doubled n times
// [R17] bit 0 of each word is its most significant bit
// [R18] offsets are byte offsets from the inquiry base address
// [R19] unmapped reads return 0, unmapped writes do nothing, bursts hold at most 32 quadlets
// [R20] all words are read-only constants chosen by a static colour variant input

package inquiry_rom_pkg;

   // =========================================================
   // address map, byte offsets from the inquiry base
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_FORMAT0_MODE = 12'h180;
   localparam logic [11:0] OFF_FORMAT1_MODE = 12'h184;
   localparam logic [11:0] OFF_FORMAT2_MODE = 12'h188;
   localparam logic [11:0] OFF_FORMAT7_MODE = 12'h19c;
   localparam logic [11:0] OFF_F0M1_RATE = 12'h204;
   localparam logic [11:0] QUADLET_STEP = 12'h004;

   // =========================================================
   // flag fields, written flag 0 leftmost so bit 0 lands on the word's msb
   localparam logic [7:0] F0_MODES_MONO = 8'h46; // [R5] [R6]
   localparam logic [7:0] F0_MODES_COLOUR = 8'h56; // [R5] [R6]
   localparam logic [7:0] F1_MODES_MONO = 8'h27;
   localparam logic [7:0] F1_MODES_COLOUR = 8'hb7;
   localparam logic [7:0] F2_MODES_MONO = 8'h27;
   localparam logic [7:0] F2_MODES_COLOUR = 8'hb7;
   localparam logic [7:0] F7_MODES_MONO = 8'h80;
   localparam logic [7:0] F7_MODES_COLOUR = 8'hc0;
   localparam logic [7:0] F0M1_RATES = 8'hf8;
   localparam int FLAG_MSB = 31;
   localparam int FLAG_LSB = 24;

   // =========================================================
   // transfer limits
   localparam int LEN_W = 6;
   localparam logic [5:0] MAX_QUADLETS = 6'h20;

   // =========================================================
   // state
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_burst = 2'b10
   } state_type;

   typedef struct packed {
      state_type state;
      logic [11:0] addr;
      logic [5:0] left;
      logic [31:0] rdata;
      logic [11:0] rd_addr;
      logic rvalid;
      logic wack;
   } regs_type;

   localparam regs_type RESET_REGS = '{
      state: st_idle,
      addr: 12'h000,
      left: 6'h00,
      rdata: 32'h0000_0000,
      rd_addr: 12'h000,
      rvalid: 1'b0,
      wack: 1'b0
   };

endpackage

// ===== hw/video_mode_rate_inquiry_rom.sv
// read-only video mode and frame-rate inquiry words answered to host reads
// assumes the link layer has already stripped bus id, node id and the inquiry base
`timescale 1ns/1ps

module video_mode_rate_inquiry_rom
   import inquiry_rom_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic colour_i,
   input wire logic req_i,
   input wire logic write_i,
   input wire logic [11:0] addr_i,
   input wire logic [5:0] len_i,
   input wire logic [31:0] wdata_i,
   output logic busy_o,
   output logic rvalid_o,
   output logic [31:0] rdata_o,
   output logic wack_o
);

   regs_type r;
   regs_type next_r;
   logic [5:0] req_len;
   logic [11:0] req_addr;

   // =========================================================
   // constant lookup
   function automatic logic [31:0] rom_word(input logic [11:0] a, input logic colour);
      logic [7:0] flags;
      flags = 8'h00;
      unique case (a)
         OFF_FORMAT0_MODE: flags = colour ? F0_MODES_COLOUR : F0_MODES_MONO; // [R1] [R3] [R4]
         OFF_FORMAT1_MODE: flags = colour ? F1_MODES_COLOUR : F1_MODES_MONO; // [R8] [R9] [R10]
         OFF_FORMAT2_MODE: flags = colour ? F2_MODES_COLOUR : F2_MODES_MONO; // [R11] [R12] [R13]
         OFF_FORMAT7_MODE: flags = colour ? F7_MODES_COLOUR : F7_MODES_MONO; // [R14]
         OFF_F0M1_RATE: flags = F0M1_RATES; // [R2] [R15] [R16]
         default: flags = 8'h00; // [R19]
      endcase
      // flag 0 goes to the msb, the reserved low 24 bits stay zero [R17] [R7]
      return {flags, 24'h00_0000};
   endfunction

   // =========================================================
   // request shaping
   // a zero length means one quadlet; longer requests are clipped to the burst limit
   assign req_len = (len_i == 6'h00) ? 6'h01 :
      ((len_i > MAX_QUADLETS) ? MAX_QUADLETS : len_i); // [R19]
   assign req_addr = {addr_i[11:2], 2'b00}; // [R18]

   // =========================================================
   // next state
   always_comb begin
      next_r = r;
      next_r.rvalid = 1'b0;
      next_r.wack = 1'b0;
      unique case (r.state)
         st_idle: begin
            if (req_i) begin
               if (write_i) begin
                  // payload is dropped: nothing here can be written [R20] [R19]
                  next_r.wack = 1'b1;
               end else begin
                  next_r.rdata = rom_word(req_addr, colour_i);
                  next_r.rd_addr = req_addr;
                  next_r.rvalid = 1'b1;
                  next_r.addr = req_addr + QUADLET_STEP;
                  next_r.left = req_len - 6'h01;
                  if (req_len > 6'h01) begin
                     next_r.state = st_burst;
                  end
               end
            end
         end
         st_burst: begin
            next_r.rdata = rom_word(r.addr, colour_i);
            next_r.rd_addr = r.addr;
            next_r.rvalid = 1'b1;
            next_r.addr = r.addr + QUADLET_STEP;
            next_r.left = r.left - 6'h01;
            if (r.left == 6'h01) begin
               next_r.state = st_idle;
            end
         end
      endcase
      // a low enable freezes everything, including the one-cycle strobes
      if (!ce_i) begin
         next_r = r;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         r <= RESET_REGS;
      end else begin
         r <= next_r;
      end
   end

   assign busy_o = (r.state == st_burst);
   assign rvalid_o = r.rvalid;
   assign rdata_o = r.rdata;
   assign wack_o = r.wack;

   // =========================================================
   // checks
   logic [6:0] burst_count;
   logic [6:0] want_len;
   wire logic [7:0] flag_seen;
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         burst_count <= 7'h00;
         want_len <= 7'h00;
      end else if (ce_i) begin
         if (r.state == st_idle && req_i && !write_i) begin
            burst_count <= 7'h01;
            want_len <= (len_i == 6'h00) ? 7'h01 :
               ((len_i > MAX_QUADLETS) ? {1'b0, MAX_QUADLETS} : {1'b0, len_i});
         end else if (r.state == st_burst) begin
            burst_count <= burst_count + 7'h01;
         end
      end
   end

   // documented flag n sits at word bit 31 - n
   for (genvar n = 0; n < 8; n++) begin : g_flag_seen
      assign flag_seen[n] = rdata_o[FLAG_MSB - n];
   end

   a_reserved_zero: assert property ( // [R7]
      @(posedge clock_i) disable iff (rst_i) rvalid_o |-> rdata_o[23:0] == 24'h00_0000)
      else $error("reserved inquiry bits not zero");

   a_format0_word: assert property ( // [R3] [R4] [R5] [R6]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == 12'h180 |->
      rdata_o[31:24] == (colour_i ? 8'h56 : 8'h46))
      else $error("format 0 mode word wrong");

   a_format1_word: assert property ( // [R8] [R9] [R10]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == 12'h184 |->
      rdata_o[31:24] == (colour_i ? 8'hb7 : 8'h27))
      else $error("format 1 mode word wrong");

   a_format2_word: assert property ( // [R11] [R12] [R13]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == 12'h188 |->
      rdata_o[31:24] == (colour_i ? 8'hb7 : 8'h27))
      else $error("format 2 mode word wrong");

   a_format7_word: assert property ( // [R14]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == 12'h19c |-> rdata_o[31] && rdata_o[30] == colour_i
      && rdata_o[29:24] == 6'h00)
      else $error("format 7 mode word wrong");

   a_rate_word: assert property ( // [R15] [R16] [R2]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == 12'h204 |-> rdata_o == 32'hf800_0000)
      else $error("format 0 mode 1 rate word wrong");

   a_unmapped_zero: assert property ( // [R19]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && !(r.rd_addr inside {12'h180, 12'h184, 12'h188, 12'h19c, 12'h204})
      |-> rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_read_answer: assert property ( // [R18]
      @(posedge clock_i) disable iff (rst_i)
      ce_i && !busy_o && req_i && !write_i |=> rvalid_o && r.rd_addr == $past(req_addr))
      else $error("read not answered next cycle");

   a_write_ignored: assert property ( // [R20]
      @(posedge clock_i) disable iff (rst_i)
      ce_i && !busy_o && req_i && write_i |=> wack_o && !rvalid_o && !busy_o)
      else $error("write not acknowledged or disturbed state");

   a_burst_limit: assert property ( // [R19]
      @(posedge clock_i) disable iff (rst_i) burst_count <= 7'h20)
      else $error("burst ran past 32 quadlets");

   // =========================================================
   // checks: format 0 mode word
   a_f0_shared_modes: assert property ( // [R3] [R5]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT0_MODE
      |-> flag_seen[1] && flag_seen[5] && flag_seen[6])
      else $error("format 0 shared mode missing");

   a_f0_colour_mode: assert property ( // [R4]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT0_MODE
      |-> flag_seen[3] == colour_i)
      else $error("format 0 colour mode flag wrong");

   a_f0_absent_modes: assert property ( // [R6]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT0_MODE
      |-> !flag_seen[0] && !flag_seen[2] && !flag_seen[4])
      else $error("format 0 absent mode flagged");

   a_f0_spare_mode: assert property ( // [R7]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT0_MODE
      |-> !flag_seen[7])
      else $error("format 0 spare mode flagged");

   // =========================================================
   // checks: format 1 mode word
   a_f1_mono_modes: assert property ( // [R8]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT1_MODE
      |-> flag_seen[2] && flag_seen[5] && flag_seen[6] && flag_seen[7])
      else $error("format 1 mono mode missing");

   a_f1_colour_modes: assert property ( // [R9]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT1_MODE
      |-> flag_seen[0] == colour_i && flag_seen[3] == colour_i)
      else $error("format 1 colour mode flag wrong");

   a_f1_rgb_modes: assert property ( // [R10]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT1_MODE
      |-> !flag_seen[1] && !flag_seen[4])
      else $error("format 1 rgb mode flagged");

   // =========================================================
   // checks: format 2 mode word
   a_f2_mono_modes: assert property ( // [R11]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT2_MODE
      |-> flag_seen[2] && flag_seen[5] && flag_seen[6] && flag_seen[7])
      else $error("format 2 mono mode missing");

   a_f2_colour_modes: assert property ( // [R12]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT2_MODE
      |-> flag_seen[0] == colour_i && flag_seen[3] == colour_i)
      else $error("format 2 colour mode flag wrong");

   a_f2_rgb_modes: assert property ( // [R13]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT2_MODE
      |-> !flag_seen[1] && !flag_seen[4])
      else $error("format 2 rgb mode flagged");

   // =========================================================
   // checks: format 7 mode word
   a_f7_first_mode: assert property ( // [R14]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT7_MODE
      |-> flag_seen[0])
      else $error("format 7 mode 0 missing");

   a_f7_colour_mode: assert property ( // [R14]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT7_MODE
      |-> flag_seen[1] == colour_i)
      else $error("format 7 mode 1 flag wrong");

   a_f7_other_modes: assert property ( // [R14]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_FORMAT7_MODE
      |-> flag_seen[7:2] == 6'h00)
      else $error("format 7 upper mode flagged");

   // =========================================================
   // checks: format 0 mode 1 rate word
   a_rate_offered: assert property ( // [R2] [R15] [R16]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_F0M1_RATE
      |-> flag_seen[4:0] == 5'h1f)
      else $error("offered frame rate missing");

   a_rate_withheld: assert property ( // [R2] [R15] [R16]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && r.rd_addr == OFF_F0M1_RATE
      |-> flag_seen[7:5] == 3'h0)
      else $error("fast frame rate flagged");

   // =========================================================
   // checks: transfers
   a_reset_quiet: assert property ( // [R20]
      @(posedge clock_i) disable iff (rst_i)
      $past(rst_i)
      |-> !rvalid_o && !wack_o && !busy_o && rdata_o == 32'h0000_0000)
      else $error("outputs not quiet after reset");

   a_frozen_hold: assert property ( // [R20]
      @(posedge clock_i) disable iff (rst_i)
      !ce_i
      |=> $stable(rdata_o) && $stable(rvalid_o) && $stable(wack_o) && $stable(busy_o))
      else $error("state moved while disabled");

   a_burst_walk: assert property ( // [R18]
      @(posedge clock_i) disable iff (rst_i)
      ce_i && busy_o
      |=> rvalid_o && r.rd_addr == $past(r.rd_addr) + QUADLET_STEP)
      else $error("burst did not step one quadlet");

   a_burst_length: assert property ( // [R19]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o && !busy_o
      |-> burst_count == want_len)
      else $error("burst length differs from request");

   a_busy_streams: assert property ( // [R19]
      @(posedge clock_i) disable iff (rst_i)
      busy_o
      |-> rvalid_o)
      else $error("busy without a quadlet");

   a_strobes_apart: assert property ( // [R20]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o
      |-> !wack_o)
      else $error("read and write strobes together");

   a_write_keeps_data: assert property ( // [R20]
      @(posedge clock_i) disable iff (rst_i)
      ce_i && !busy_o && req_i && write_i
      |=> $stable(rdata_o))
      else $error("write changed read data");

   a_long_request: assert property ( // [R19]
      @(posedge clock_i) disable iff (rst_i)
      ce_i && !busy_o && req_i && !write_i && len_i > 6'h01
      |=> busy_o)
      else $error("multi quadlet read did not start a burst");

   a_short_request: assert property ( // [R19]
      @(posedge clock_i) disable iff (rst_i)
      ce_i && !busy_o && req_i && !write_i && len_i <= 6'h01
      |=> !busy_o)
      else $error("single quadlet read started a burst");

   a_quadlet_aligned: assert property ( // [R18]
      @(posedge clock_i) disable iff (rst_i)
      rvalid_o
      |-> r.rd_addr[1:0] == 2'b00)
      else $error("answered address not quadlet aligned");

endmodule

// ===== bench/inquiry_host_model.sv
// host side model: issues single reads, burst reads and writes to the inquiry rom
// assumes the rom takes a request at a rising edge while idle and enabled
`timescale 1ns/1ps

module inquiry_host_model (
   input wire logic clock_i,
   output logic req_o,
   output logic write_o,
   output logic [11:0] addr_o,
   output logic [5:0] len_o,
   output logic [31:0] wdata_o
);
   // =========================================================
   // request driver
   initial begin
      req_o = 1'b0;
      write_o = 1'b0;
      addr_o = 12'h000;
      len_o = 6'h00;
      wdata_o = 32'h0000_0000;
   end

   // held over one rising edge, then released to inverted junk so stale values never match
   task send(input logic w, input logic [11:0] a, input logic [5:0] n, input logic [31:0] d);
      @(negedge clock_i);
      req_o = 1'b1;
      write_o = w;
      addr_o = a;
      len_o = n;
      wdata_o = d;
      @(negedge clock_i);
      req_o = 1'b0;
      write_o = ~w;
      addr_o = ~a;
      len_o = ~n;
      wdata_o = ~d;
   endtask
endmodule

// ===== bench/video_mode_rate_inquiry_rom_tb_top.sv
// self-checking bench for the inquiry rom: table, bursts, writes, random reads
// assumes the host model drives requests at falling edges
`timescale 1ns/1ps

module video_mode_rate_inquiry_rom_tb_top;
   import inquiry_rom_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic colour = 1'b0;
   logic req, write, busy, rvalid, wack;
   logic [11:0] addr;
   logic [5:0] len;
   logic [31:0] wdata, rdata;
   int error_cnt = 0;
   int compares = 0;
   logic [11:0] offs [6] = '{12'h180, 12'h184, 12'h188, 12'h19c, 12'h204, 12'h18c};

   always #5 clock_i = ~clock_i;

   inquiry_host_model u_host (.clock_i(clock_i), .req_o(req), .write_o(write), .addr_o(addr),
      .len_o(len), .wdata_o(wdata));
   video_mode_rate_inquiry_rom u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
      .colour_i(colour), .req_i(req), .write_i(write), .addr_i(addr), .len_i(len),
      .wdata_i(wdata), .busy_o(busy), .rvalid_o(rvalid), .rdata_o(rdata), .wack_o(wack));

   // =========================================================
   // expected words, flag 0 lands on bit 31
   function automatic logic [31:0] exp_word(input logic [11:0] a, input logic c);
      logic [7:0] f;
      case ({a[11:2], 2'b00})
         12'h180: f = {1'b0, 1'b1, 1'b0, c, 1'b0, 1'b1, 1'b1, 1'b0};
         12'h184, 12'h188: f = {c, 1'b0, 1'b1, c, 1'b0, 1'b1, 1'b1, 1'b1};
         12'h19c: f = {1'b1, c, 6'h00};
         12'h204: f = 8'hf8;
         default: f = 8'h00;
      endcase
      return {f, 24'h00_0000};
   endfunction

   task chk(input string what, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask

   // =========================================================
   // bus tasks
   task rd(input logic [11:0] a, input logic [5:0] n, input logic c);
      int q;
      q = (n == 6'h00) ? 1 : ((n > 6'h20) ? 32 : int'(n));
      colour = c;
      u_host.send(1'b0, a, n, 32'($urandom));
      // quadlet 0 already stands at the falling edge that ends the request
      for (int k = 0; k < q; k++) begin
         if (k > 0) begin
            @(negedge clock_i);
         end
         chk("rvalid", 32'h1, {31'h0, rvalid});
         chk("busy", 32'(k < q - 1), {31'h0, busy});
         chk("rdata", exp_word(a + 12'(k * 4), c), rdata);
      end
      @(negedge clock_i);
      chk("rvalid end", 32'h0, {31'h0, rvalid});
      chk("busy end", 32'h0, {31'h0, busy});
   endtask

   task wr(input logic [11:0] a);
      u_host.send(1'b1, a, 6'($urandom), 32'($urandom));
      chk("wack", 32'h1, {31'h0, wack});
      chk("rvalid on write", 32'h0, {31'h0, rvalid});
      @(negedge clock_i);
      chk("wack end", 32'h0, {31'h0, wack});
   endtask

   task finish_test;
      $display("checks %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // =========================================================
   // scenarios
   initial begin
      void'($urandom(5287));
      repeat (10) @(negedge clock_i);
      rst_i = 1'b0;
      chk("rdata reset", 32'h0, rdata);
      chk("wack reset", 32'h0, {31'h0, wack});
      for (int c = 0; c < 2; c++) begin
         foreach (offs[i]) rd(offs[i], 6'h01, c[0]);
         foreach (offs[i]) rd(offs[i] + 12'h002, 6'h00, c[0]);
         rd(12'h180, 6'h20, c[0]);
      end
      rd(12'h17c, 6'h28, 1'b1);
      // writes only acknowledge; the word must read back untouched
      wr(12'h180);
      wr(12'h300);
      rd(12'h180, 6'h02, 1'b1);
      // a request while disabled is ignored without any answer
      ce_i = 1'b0;
      u_host.send(1'b0, 12'h180, 6'h01, 32'h0);
      ce_i = 1'b1;
      repeat (2) begin
         @(negedge clock_i);
         chk("rvalid frozen", 32'h0, {31'h0, rvalid});
      end
      // reset in the middle of a burst must silence it at once
      u_host.send(1'b0, 12'h180, 6'h08, 32'h0);
      rst_i = 1'b1;
      @(negedge clock_i);
      chk("busy reset", 32'h0, {31'h0, busy});
      chk("rvalid reset", 32'h0, {31'h0, rvalid});
      chk("rdata reset", 32'h0, rdata);
      rst_i = 1'b0;
      @(negedge clock_i);
      chk("rvalid after reset", 32'h0, {31'h0, rvalid});
      repeat (40) rd(12'h170 + 12'($urandom_range(40) * 4), 6'($urandom_range(5)),
         1'($urandom));
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      finish_test();
   end
endmodule
